/* verilog/gbmr_responder.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - device clear of either kind acts only in remote control
// - selected clear needs listener role; universal clear acts in any addressed state
// - accepted clear presets instrument settings, bus interface state untouched
// - own listen address: become listener, go remote if remote enable true, drop talker
// - own talk address: become talker, drop listener
// - another device's talk address drops our talker role
// - local lockout disables local key; cleared by remote enable false
// - serial poll enable: poll mode, talker sends status byte
// - serial poll disable: idle, talker sends measurement data
// - go to local while listener returns to local control
// - untalk drops talker; unlisten drops listener; addressed lamp lit while talker or listener
// - commands run together; commas, spaces, semicolons ignored
// - six terminators recognised, including any last byte with end
// - two-character preset command restores power-up settings
// - attention-false bytes are device commands, only when listener
// - unsupported interface messages are handshaken and ignored
module gbmr_responder
    import gbmr_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    // bus pins
    input  wire logic       dav_i,
    input  wire logic       atn_i,
    input  wire logic       eoi_i,
    input  wire logic       ren_i,
    input  wire logic [7:0] dio_i,
    // address switch
    input  wire logic [4:0] addr_sw_i,
    // instrument side
    input  wire logic       meas_busy_i,
    output var  logic       listener_o,
    output var  logic       talker_o,
    output var  logic       remote_o,
    output var  logic       lockout_o,
    output var  logic       local_key_en_o,
    output var  logic       addr_lamp_o,
    output var  logic       send_status_o,
    output var  logic       send_data_o,
    output var  logic       preset_o,
    output var  logic       trigger_o,
    output var  logic       cmd_stb_o,
    output var  logic [7:0] cmd_byte_o,
    output var  logic       end_of_string_o
);
    import gbmr_pkg::*;

    gbmr_byte_if bif ();

    gbmr_pin_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .dav_i     (dav_i),
        .atn_i     (atn_i),
        .eoi_i     (eoi_i),
        .ren_i     (ren_i),
        .dio_i     (dio_i),
        .byte_o    (bif.src)
    );

    typedef enum logic [1:0] {
        GBMR_PS_IDLE = 2'b00,
        GBMR_PS_I    = 2'b01,
        GBMR_PS_CR   = 2'b10
    } gbmr_parse_e;

    typedef struct packed {
        logic        lstn;
        logic        talk;
        logic        rem;
        logic        llo;
        logic        spms;
        logic        preset;
        logic        trig;
        logic        cstb;
        logic [7:0]  cbyte;
        logic        eos;
        gbmr_parse_e ps;
    } gbmr_state_s;

    gbmr_state_s st_reg, st_next;

    // address match helper, used for the listen group only; talk group compares inline
    function automatic logic gbmr_addr_hit(input logic [7:0] b, input logic [1:0] grp,
                                           input logic [4:0] sw);
        gbmr_addr_hit = (b[GBMR_GRP_HI:GBMR_GRP_LO] == grp) && (b[GBMR_ADR_HI:0] == sw);
    endfunction : gbmr_addr_hit

    logic [6:0] cmd;
    logic       is_sep;
    assign cmd    = bif.data[6:0];
    assign is_sep = (bif.data == GBMR_CH_COMMA) || (bif.data == GBMR_CH_SP)
                  || (bif.data == GBMR_CH_SEMI);

    // interface message and data byte decode
    always_comb begin
        st_next        = st_reg;
        st_next.preset = 1'b0;
        st_next.trig   = 1'b0;
        st_next.cstb   = 1'b0;
        st_next.eos    = 1'b0;
        if (!bif.ren) begin
            st_next.rem = 1'b0;
            st_next.llo = 1'b0;
        end
        if (bif.stb && bif.atn) begin
            if (gbmr_addr_hit(bif.data, GBMR_GRP_LISTEN, addr_sw_i)) begin
                st_next.lstn = 1'b1;
                st_next.talk = 1'b0;
                st_next.rem  = bif.ren;
            end else if (bif.data[GBMR_GRP_HI:GBMR_GRP_LO] == GBMR_GRP_TALK
                         && cmd != GBMR_CMD_UNT) begin
                // own talk address takes talker; any other drops it
                st_next.talk = (bif.data[GBMR_ADR_HI:0] == addr_sw_i);
                if (bif.data[GBMR_ADR_HI:0] == addr_sw_i) begin
                    st_next.lstn = 1'b0;
                end
            end else begin
                case (cmd)
                    GBMR_CMD_LLO: st_next.llo = 1'b1;
                    GBMR_CMD_DCL: st_next.preset = st_reg.rem;
                    GBMR_CMD_SDC: st_next.preset = st_reg.rem && st_reg.lstn;
                    GBMR_CMD_SPE: st_next.spms = 1'b1;
                    GBMR_CMD_SPD: st_next.spms = 1'b0;
                    GBMR_CMD_GET: st_next.trig = st_reg.lstn && !meas_busy_i;
                    GBMR_CMD_GTL: begin
                        if (st_reg.lstn) begin
                            st_next.rem = 1'b0;
                        end
                    end
                    GBMR_CMD_UNT: st_next.talk = 1'b0;
                    GBMR_CMD_UNL: st_next.lstn = 1'b0;
                    default: ; // handshaken elsewhere, no action
                endcase
            end
        end else if (bif.stb && st_reg.lstn) begin
            // terminator detection; a held CR waits for LF
            if (bif.data == GBMR_CH_LF || bif.eoi) begin
                st_next.eos = 1'b1;
                st_next.ps  = GBMR_PS_IDLE;
            end else if (bif.data == GBMR_CH_CR) begin
                st_next.ps = GBMR_PS_CR;
            end
            // command bytes pass on; separators dropped
            if (!is_sep && bif.data != GBMR_CH_LF && bif.data != GBMR_CH_CR) begin
                st_next.cstb  = 1'b1;
                st_next.cbyte = bif.data;
            end
            case (st_reg.ps)
                GBMR_PS_I: begin
                    if (bif.data == GBMR_CH_P) begin
                        st_next.preset = 1'b1;
                    end
                end
                default: ;
            endcase
            if (!st_next.eos && bif.data == GBMR_CH_I) begin
                st_next.ps = GBMR_PS_I;
            end else if (!st_next.eos && bif.data != GBMR_CH_CR && !is_sep) begin
                st_next.ps = GBMR_PS_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // registered outputs; preset leaves bus roles untouched
    always_comb begin
        listener_o      = st_reg.lstn;
        talker_o        = st_reg.talk;
        remote_o        = st_reg.rem;
        lockout_o       = st_reg.llo;
        local_key_en_o  = !st_reg.llo;
        addr_lamp_o     = st_reg.lstn || st_reg.talk;
        send_status_o   = st_reg.talk && st_reg.spms;
        send_data_o     = st_reg.talk && !st_reg.spms;
        preset_o        = st_reg.preset;
        trigger_o       = st_reg.trig;
        cmd_stb_o       = st_reg.cstb;
        cmd_byte_o      = st_reg.cbyte;
        end_of_string_o = st_reg.eos;
    end

    // clear needs remote control
    a_clear_remote: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && cmd == GBMR_CMD_DCL && !st_reg.rem && bif.ren) |=> !preset_o)
        else $error("clear acted outside remote");
    // selected clear needs listener
    a_sdc_listen: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && cmd == GBMR_CMD_SDC)
        |=> preset_o == ($past(st_reg.rem) && $past(st_reg.lstn)))
        else $error("selected clear gating wrong");
    // own listen address
    a_listen_addr: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && bif.data[6:0] == {GBMR_GRP_LISTEN, addr_sw_i})
        |=> listener_o && !talker_o && remote_o == $past(bif.ren))
        else $error("listen address not taken");
    // own talk address
    a_talk_addr: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && bif.data[6:0] == {GBMR_GRP_TALK, addr_sw_i})
        |=> talker_o && !listener_o)
        else $error("talk address not taken");
    // other talk address
    a_other_talk: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && bif.data[6:5] == 2'b10 && bif.data[4:0] != addr_sw_i) |=> !talker_o)
        else $error("talker kept after other talk");
    // lockout
    a_lockout: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && cmd == GBMR_CMD_LLO && bif.ren) |=> !local_key_en_o)
        else $error("lockout ignored");
    // poll mode
    a_poll_mode: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && cmd == GBMR_CMD_SPE)
        |=> send_status_o == talker_o && !send_data_o)
        else $error("status and data both sent");
    // unlisten
    a_unlisten: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (bif.stb && bif.atn && cmd == GBMR_CMD_UNL) |=> !listener_o)
        else $error("unlisten ignored");
    // trigger
    a_trigger: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        trigger_o |-> $past(st_reg.lstn) && !$past(meas_busy_i))
        else $error("trigger not gated");
endmodule : gbmr_responder
`default_nettype wire

/* verilog/gbmr_pkg.sv */
package gbmr_pkg;
    // interface message codes seen with attention true (7-bit)
    localparam logic [6:0] GBMR_CMD_GTL = 7'h01;
    localparam logic [6:0] GBMR_CMD_SDC = 7'h04;
    localparam logic [6:0] GBMR_CMD_GET = 7'h08;
    localparam logic [6:0] GBMR_CMD_LLO = 7'h11;
    localparam logic [6:0] GBMR_CMD_DCL = 7'h14;
    localparam logic [6:0] GBMR_CMD_SPE = 7'h18;
    localparam logic [6:0] GBMR_CMD_SPD = 7'h19;
    localparam logic [6:0] GBMR_CMD_UNL = 7'h3f;
    localparam logic [6:0] GBMR_CMD_UNT = 7'h5f;
    // address group field layout
    localparam logic [1:0] GBMR_GRP_LISTEN = 2'h1;
    localparam logic [1:0] GBMR_GRP_TALK   = 2'h2;
    localparam int         GBMR_GRP_HI     = 6;
    localparam int         GBMR_GRP_LO     = 5;
    localparam int         GBMR_ADR_HI     = 4;
    // data bytes of interest
    localparam logic [7:0] GBMR_CH_LF    = 8'h0a;
    localparam logic [7:0] GBMR_CH_CR    = 8'h0d;
    localparam logic [7:0] GBMR_CH_SP    = 8'h20;
    localparam logic [7:0] GBMR_CH_COMMA = 8'h2c;
    localparam logic [7:0] GBMR_CH_SEMI  = 8'h3b;
    localparam logic [7:0] GBMR_CH_I     = 8'h49;
    localparam logic [7:0] GBMR_CH_P     = 8'h50;
    // synchroniser depth for pin inputs
    localparam int         GBMR_SYNC_N   = 3;
endpackage : gbmr_pkg

/* verilog/gbmr_byte_if.sv */
`timescale 1ns/100ps
`default_nettype none
// accepted byte from the pin front end to the decoder
interface gbmr_byte_if;
    logic       stb;
    logic       atn;
    logic       eoi;
    logic       ren;
    logic [7:0] data;
    modport src (output stb, output atn, output eoi, output ren, output data);
    modport dst (input stb, input atn, input eoi, input ren, input data);
endinterface : gbmr_byte_if
`default_nettype wire

/* verilog/gbmr_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// synchronises bus pins and emits one strobe per data-valid rising edge
module gbmr_pin_sync
    import gbmr_pkg::*;
(
    // clock and reset
    input  wire logic  ref_clk_i,
    input  wire logic  reset_n_i,
    // raw bus pins
    input  wire logic  dav_i,
    input  wire logic  atn_i,
    input  wire logic  eoi_i,
    input  wire logic  ren_i,
    input  wire logic [7:0] dio_i,
    // synchronised byte
    gbmr_byte_if.src   byte_o
);
    typedef struct packed {
        logic [GBMR_SYNC_N-1:0] dav;
        logic [GBMR_SYNC_N-1:0] atn;
        logic [GBMR_SYNC_N-1:0] eoi;
        logic [GBMR_SYNC_N-1:0] ren;
        logic                   dav_q;
    } gbmr_sync_s;
    gbmr_sync_s st_reg, st_next;

    // shift chains; a data-valid level counts once stages two and three agree, other flags use stage three alone
    always_comb begin
        st_next     = st_reg;
        st_next.dav = {st_reg.dav[1:0], dav_i};
        st_next.atn = {st_reg.atn[1:0], atn_i};
        st_next.eoi = {st_reg.eoi[1:0], eoi_i};
        st_next.ren = {st_reg.ren[1:0], ren_i};
        if (st_reg.dav[2] == st_reg.dav[1]) begin
            st_next.dav_q = st_reg.dav[2];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // data and flags are stable while data-valid is high
    assign byte_o.stb  = (st_reg.dav[2] == st_reg.dav[1]) && st_reg.dav[2] && !st_reg.dav_q;
    assign byte_o.atn  = st_reg.atn[2];
    assign byte_o.eoi  = st_reg.eoi[2];
    assign byte_o.ren  = st_reg.ren[2];
    assign byte_o.data = dio_i;
endmodule : gbmr_pin_sync
`default_nettype wire

/* tb/gbmr_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
// controller on the far side: sources bytes with a full data-valid cycle
module gbmr_ctrl_model (
    // clock
    input  wire logic       ref_clk_i,
    // bus lines toward the device
    output var  logic       dav_o,
    output var  logic       atn_o,
    output var  logic       eoi_o,
    output var  logic       ren_o,
    output var  logic [7:0] dio_o
);
    // idle bus at time zero
    initial begin
        dav_o = 1'b0;
        atn_o = 1'b0;
        eoi_o = 1'b0;
        ren_o = 1'b0;
        dio_o = 8'h00;
    end

    // one byte: lines set with data valid, held, then valid dropped for the gap
    task automatic send(input logic atn, input logic eoi, input logic [7:0] data);
        @(negedge ref_clk_i);
        atn_o = atn;
        eoi_o = eoi;
        dio_o = data;
        dav_o = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        dav_o = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        dio_o = ~data; // released lines no longer show the byte
        eoi_o = ~eoi;
    endtask : send

    // remote enable; false returns all devices to local and clears lockout
    task automatic set_ren(input logic val);
        @(negedge ref_clk_i);
        ren_o = val;
        repeat (6) @(negedge ref_clk_i);
    endtask : set_ren
endmodule : gbmr_ctrl_model
`default_nettype wire

/* tb/tb_gbmr_responder.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_gbmr_responder;
    import gbmr_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       dav, atn, eoi, ren, busy;
    logic [7:0] dio, cbyte, last_cb;
    logic [4:0] me, other;
    logic       lsn_o, tlk_o, rem_o, llo_o, key_o, lamp_o, st_o, dt_o, pre_o, trg_o, stb_o, eos_o;
    int         failures = 0;
    int         tests_run = 0;
    int         n_pre, n_trg, n_stb, n_eos, n;
    logic [31:0] rng = 32'h17;
    string      s = "I, ;P\n";
    logic [7:0] t1 [6] = '{GBMR_CH_LF, GBMR_CH_LF, GBMR_CH_CR, GBMR_CH_CR, GBMR_CH_CR, 8'h41};
    logic [7:0] t2 [6] = '{8'h00, 8'h00, 8'h00, GBMR_CH_LF, GBMR_CH_LF, 8'h00};
    logic [5:0] te = 6'b110110; // end asserted on the last byte of group i

    // clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    gbmr_ctrl_model ctl_u (.ref_clk_i(ref_clk_i), .dav_o(dav), .atn_o(atn), .eoi_o(eoi),
        .ren_o(ren), .dio_o(dio));

    gbmr_responder dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .dav_i(dav),
        .atn_i(atn), .eoi_i(eoi), .ren_i(ren), .dio_i(dio), .addr_sw_i(me),
        .meas_busy_i(busy), .listener_o(lsn_o), .talker_o(tlk_o), .remote_o(rem_o),
        .lockout_o(llo_o), .local_key_en_o(key_o), .addr_lamp_o(lamp_o),
        .send_status_o(st_o), .send_data_o(dt_o), .preset_o(pre_o), .trigger_o(trg_o),
        .cmd_stb_o(stb_o), .cmd_byte_o(cbyte), .end_of_string_o(eos_o));

    // pulse counters, so one-cycle outputs are seen in their own cycle
    always @(posedge ref_clk_i) begin
        if (pre_o === 1'b1) n_pre++;
        if (trg_o === 1'b1) n_trg++;
        if (eos_o === 1'b1) n_eos++;
        if (stb_o === 1'b1) begin
            n_stb++;
            last_cb = cbyte;
        end
    end

    function logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    // expected address byte for a group and address
    function logic [7:0] adr(input logic [1:0] grp, input logic [4:0] a);
        return {1'b0, grp, a};
    endfunction : adr

    task close_out();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task chk_n(input int got, input int exp, input string what);
        tests_run++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH at %0t: %s count %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_n

    task clr();
        n_pre = 0;
        n_trg = 0;
        n_stb = 0;
        n_eos = 0;
    endtask : clr

    task cmd(input logic [6:0] c);
        ctl_u.send(1'b1, 1'b0, {1'b0, c});
    endtask : cmd

    task done(input string name);
        $display("test %s done", name);
    endtask : done

    // watchdog
    initial begin
        #200000;
        failures++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end

    // main sequence
    initial begin
        busy = 1'b0;
        me = 5'(xs() % 31);
        other = 5'((me + 1) % 31);
        clr();
        repeat (2) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        chk(lsn_o, 0, "lsn");
        chk(tlk_o, 0, "tlk");
        chk(rem_o, 0, "rem");
        chk(key_o, 1, "key");
        done("reset");
        ctl_u.set_ren(1'b1);
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_LISTEN, me));
        chk(lsn_o, 1, "lsn");
        chk(rem_o, 1, "rem");
        chk(lamp_o, 1, "lamp");
        chk(tlk_o, 0, "tlk");
        clr();
        for (int i = 0; i < s.len(); i++) ctl_u.send(1'b0, 1'b0, s[i]);
        chk_n(n_pre, 1, "preset");
        chk_n(n_eos, 1, "eos");
        for (int i = 0; i < 6; i++) begin
            clr();
            ctl_u.send(1'b0, (t2[i] == 8'h00) ? te[i] : 1'b0, t1[i]);
            if (t2[i] != 8'h00) ctl_u.send(1'b0, te[i], t2[i]);
            chk_n(n_eos, 1, "terminator");
        end
        clr();
        n = 1 + xs() % 6;
        for (int j = 0; j < n; j++) ctl_u.send(1'b0, 1'b0, 8'h30 + 8'(xs() % 10));
        chk_n(n_stb, n, "data strobes");
        chk(last_cb, dio ^ 8'hff, "last byte");
        done("listen data");
        clr();
        cmd(GBMR_CMD_GET);
        chk_n(n_trg, 1, "trigger idle");
        busy = 1'b1;
        cmd(GBMR_CMD_GET);
        chk_n(n_trg, 1, "trigger busy");
        busy = 1'b0;
        cmd(GBMR_CMD_SDC);
        chk_n(n_pre, 1, "selected clear");
        cmd(GBMR_CMD_DCL);
        chk_n(n_pre, 2, "clear");
        chk(lsn_o, 1, "lsn after clear");
        done("trigger and clear");
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_TALK, me));
        chk(tlk_o, 1, "tlk");
        chk(lsn_o, 0, "lsn");
        cmd(GBMR_CMD_SPE);
        chk(st_o, 1, "status");
        chk(dt_o, 0, "data");
        cmd(GBMR_CMD_SPD);
        chk(st_o, 0, "status");
        chk(dt_o, 1, "data");
        clr();
        ctl_u.send(1'b0, 1'b0, GBMR_CH_I);
        ctl_u.send(1'b0, 1'b0, GBMR_CH_P);
        chk_n(n_stb + n_pre, 0, "unaddressed data");
        cmd(GBMR_CMD_SDC);
        chk_n(n_pre, 0, "selected clear unaddressed");
        cmd(GBMR_CMD_DCL);
        chk_n(n_pre, 1, "clear unaddressed");
        chk(tlk_o, 1, "tlk after clear");
        done("talker");
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_LISTEN, me));
        cmd(GBMR_CMD_GTL);
        chk(rem_o, 0, "rem");
        clr();
        cmd(GBMR_CMD_DCL);
        chk_n(n_pre, 0, "clear in local");
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_LISTEN, me));
        cmd(7'h15);
        chk({lsn_o, rem_o, tlk_o, llo_o}, 4'hc, "unsupported");
        cmd(GBMR_CMD_LLO);
        chk(llo_o, 1, "lockout");
        chk(key_o, 0, "key");
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_TALK, me));
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_TALK, other));
        chk(tlk_o, 0, "other talker");
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_TALK, me));
        cmd(GBMR_CMD_UNT);
        chk(tlk_o, 0, "untalk");
        ctl_u.send(1'b1, 1'b0, adr(GBMR_GRP_LISTEN, me));
        cmd(GBMR_CMD_UNL);
        chk(lsn_o, 0, "unlisten");
        chk(lamp_o, 0, "lamp");
        ctl_u.set_ren(1'b0);
        chk({llo_o, rem_o, key_o}, 3'h1, "remote enable false");
        done("addressing");
        close_out();
    end
endmodule : tb_gbmr_responder
`default_nettype wire
